// *** src/aidf_cfg.svh ***
`ifndef AIDF_CFG_SVH
`define AIDF_CFG_SVH

// Register byte offsets
`define AIDF_OFS_CTRL      8'h00
`define AIDF_OFS_STATUS    8'h04
`define AIDF_OFS_MASK      8'h08
`define AIDF_OFS_CALTRIM   8'h0C
`define AIDF_OFS_DATA0     8'h10
`define AIDF_OFS_DATA7     8'h2C

// Control field positions
`define AIDF_CTRL_EIGHT    0
`define AIDF_CTRL_A_RNG    1
`define AIDF_CTRL_A_FMT    4
`define AIDF_CTRL_B_RNG    5
`define AIDF_CTRL_B_FMT    8
`define AIDF_CTRL_CAL_EN   9
`define AIDF_CTRL_RESET    10'h201

// Status and mask bit positions
`define AIDF_ST_OOR        0
`define AIDF_ST_CAL        1
`define AIDF_ST_SCAN       2

// Data word layout
`define AIDF_DW_OOR        15
`define AIDF_DW_ERR        14

// Count limits
`define AIDF_RAW_MAX       14'sh1068
`define AIDF_NOM_COUNTS    4096
`define AIDF_CB_MAX        14'h270F

// Calibration reference target and tolerance
`define AIDF_CAL_REF       14'sh0800
`define AIDF_CAL_TOL       14'sh0002

// Timing
`define AIDF_CLK_PERIOD_NS 25
`define AIDF_UPD4_NS       2400000
`define AIDF_UPD8_NS       3000000
`define AIDF_SLOT4_CYC     (`AIDF_UPD4_NS / (`AIDF_CLK_PERIOD_NS * 5))
`define AIDF_SLOT8_CYC     (`AIDF_UPD8_NS / (`AIDF_CLK_PERIOD_NS * 9))

`endif

// *** src/aidf_pkg.sv ***
package aidf_pkg;

  // Input span selection per group
  typedef enum logic [2:0] {
    AIDF_RNG_0_5    = 3'b000,
    AIDF_RNG_0_10   = 3'b001,
    AIDF_RNG_1_5    = 3'b010,
    AIDF_RNG_BIP_10 = 3'b011,
    AIDF_RNG_BIP_5  = 3'b100
  } aidf_range_t;

  // Group settings
  typedef struct packed {
    aidf_range_t full_scale_span;
    logic        scaled_decimal_format;
  } aidf_grp_cfg_t;

  // Converter result
  typedef struct packed {
    logic              valid;
    logic              cal;
    logic [2:0]        chan;
    logic signed [13:0] code;
  } aidf_sample_t;

  // Converter request
  typedef struct packed {
    logic       req;
    logic       cal;
    logic [2:0] chan;
  } aidf_conv_req_t;

endpackage : aidf_pkg

// *** src/aidf_top.sv ***
`timescale 1ns/1ps
`include "aidf_cfg.svh"
// Summary of operation
// R01 - Channels split into groups A and B; split point depends on four/eight mode.
// R02 - Each group selects one of five input spans governing scaling.
// R03 - Up to 2% over span is not out of range; none below.
// R04 - Every channel refreshed within 2.4 ms (four) or 3.0 ms (eight).
// R05 - Calibration checked in background, trim corrected only on drift, conversions continue.
// R06 - Results carry twelve bits of resolution, 4096 counts nominal span.
// R07 - Raw count value held between 0 and 4200 for every span.
// R08 - Raw or converted format selected separately per group.
// R09 - Converted value computed from raw count as unsigned four-digit reading.
// R10 - Controller uses converted format only with unipolar spans.
// R11 - Good data clears data word bits 14 and 15; bit 15 stays set for 15 good samples after a clipped one.
// R12 - Out-of-range data sets bit 15, clears bit 14, lights indicator.
// R13 - Samples below 0 or above 4200 clamped before averaging.
// R14 - Sixteen-bit word, value right-justified, status bits separate.
module aidf_top
  import aidf_pkg::*;
#(
  parameter int SLOT4_CYC  = `AIDF_SLOT4_CYC,
  parameter int SLOT8_CYC  = `AIDF_SLOT8_CYC,
  parameter int AVG_SHIFT  = 2,
  parameter int CAL_EVERY  = 16
)(
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic [7:0]     s_axi_awaddr,
  input  wire logic           s_axi_awvalid,
  output logic                s_axi_awready,
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  input  wire logic           s_axi_wvalid,
  output logic                s_axi_wready,
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  wire logic           s_axi_bready,
  input  wire logic [7:0]     s_axi_araddr,
  input  wire logic           s_axi_arvalid,
  output logic                s_axi_arready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  wire logic           s_axi_rready,
  input  wire aidf_sample_t   sample,
  output aidf_conv_req_t      conv,
  output logic signed [7:0]   cal_trim,
  output logic                oor_led,
  output logic                irq
);

  // Software state
  logic [9:0]          ctrl_r;
  logic [2:0]          status_r;
  logic [2:0]          mask_r;
  logic signed [7:0]   trim_r;
  aidf_grp_cfg_t       grp_a;
  aidf_grp_cfg_t       grp_b;
  logic                eight_mode;

  // Channel storage
  logic [13+AVG_SHIFT:0] acc_r [8];
  logic [15:0]           word_r [8];
  logic [7:0]            oor_cnt_r [8];

  // Scheduler
  logic [15:0]         slot_cnt_r;
  logic [3:0]          slot_idx_r;
  logic [7:0]          cal_cnt_r;
  aidf_conv_req_t      conv_r;

  // Events
  logic                ev_oor;
  logic                ev_cal;
  logic                ev_scan;

  // Bus handshake state
  logic                aw_hold_r;
  logic                w_hold_r;
  logic [7:0]          aw_addr_r;
  logic [31:0]         w_data_r;
  logic [3:0]          w_strb_r;
  logic                wr_go;

  assign eight_mode = ctrl_r[`AIDF_CTRL_EIGHT];
  assign grp_a      = aidf_grp_cfg_t'({ctrl_r[`AIDF_CTRL_A_RNG +: 3], ctrl_r[`AIDF_CTRL_A_FMT]}); // [R02] [R08]
  assign grp_b      = aidf_grp_cfg_t'({ctrl_r[`AIDF_CTRL_B_RNG +: 3], ctrl_r[`AIDF_CTRL_B_FMT]}); // [R02] [R08]

  // Group B starts at channel 4 (eight) or channel 2 (four)
  function automatic logic in_grp_b(input logic [2:0] ch, input logic eight);
    in_grp_b = eight ? ch[2] : ch[1]; // [R01]
  endfunction : in_grp_b

  // Scale raw counts to an unsigned millivolt-like reading
  function automatic logic [13:0] to_decimal(input logic [12:0] raw, input aidf_range_t rng);
    logic [27:0] prod;
    logic [27:0] val;
    prod = 28'h0000000;
    val  = 28'h0000000;
    case (rng)
      AIDF_RNG_0_5:  prod = 28'(raw) * 28'd5000;
      AIDF_RNG_0_10: prod = 28'(raw) * 28'd10000;
      AIDF_RNG_1_5:  prod = 28'(raw) * 28'd4000;
      default:       prod = 28'(raw) * 28'd4096;
    endcase
    val = (prod + 28'h0000800) >> 12; // [R09] rounded
    if (rng == AIDF_RNG_1_5)
      val = val + 28'd1000; // Live zero offset
    if (val > 28'(`AIDF_CB_MAX))
      val = 28'(`AIDF_CB_MAX); // Four digits only
    to_decimal = val[13:0];
  endfunction : to_decimal

  // Clamp a converter code to the raw count window
  function automatic logic [12:0] clamp_raw(input logic signed [13:0] code);
    if (code < 14'sh0000)
      clamp_raw = 13'h0000; // [R13] [R03] no under margin
    else if (code > `AIDF_RAW_MAX)
      clamp_raw = 13'h1068; // [R13] [R07]
    else
      clamp_raw = code[12:0]; // [R06] 2% over span kept [R03]
  endfunction : clamp_raw

  // Slot scheduler: one slot per channel plus one for calibration
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      slot_cnt_r <= 16'h0000;
      slot_idx_r <= 4'h0;
      conv_r     <= '0;
    end
    else
    begin
      conv_r.req <= 1'b0;
      if (32'(slot_cnt_r) >= (eight_mode ? SLOT8_CYC : SLOT4_CYC) - 1) // [R04]
      begin
        slot_cnt_r  <= 16'h0000;
        conv_r.req  <= 1'b1;
        conv_r.cal  <= (slot_idx_r == (eight_mode ? 4'h8 : 4'h4)); // [R05] interleaved
        conv_r.chan <= slot_idx_r[2:0];
        if (slot_idx_r >= (eight_mode ? 4'h8 : 4'h4))
          slot_idx_r <= 4'h0;
        else
          slot_idx_r <= slot_idx_r + 4'h1;
      end
      else
        slot_cnt_r <= slot_cnt_r + 16'h0001;
    end
  end

  assign ev_scan = conv_r.req && conv_r.cal;

  // Background trim: correct only when the reference reading drifts
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trim_r    <= 8'sh00;
      cal_cnt_r <= 8'h00;
    end
    else if (sample.valid && sample.cal && ctrl_r[`AIDF_CTRL_CAL_EN])
    begin
      cal_cnt_r <= (32'(cal_cnt_r) >= CAL_EVERY - 1) ? 8'h00 : cal_cnt_r + 8'h01;
      if (sample.code > `AIDF_CAL_REF + `AIDF_CAL_TOL && trim_r != 8'sh80)
        trim_r <= trim_r - 8'sh01; // [R05]
      else if (sample.code < `AIDF_CAL_REF - `AIDF_CAL_TOL && trim_r != 8'sh7F)
        trim_r <= trim_r + 8'sh01; // [R05]
    end
  end

  assign ev_cal = sample.valid && sample.cal && ctrl_r[`AIDF_CTRL_CAL_EN]
                  && (sample.code > `AIDF_CAL_REF + `AIDF_CAL_TOL || sample.code < `AIDF_CAL_REF - `AIDF_CAL_TOL);
  assign ev_oor = sample.valid && !sample.cal && (sample.code < 14'sh0000 || sample.code > `AIDF_RAW_MAX);

  // Per-channel averaging and word assembly
  for (genvar c = 0; c < 8; c++)
  begin : g_chan
    logic                  hit;
    logic                  clip;
    logic [12:0]           x;
    logic [13+AVG_SHIFT:0] acc_nxt;
    logic [12:0]           avg;
    logic [7:0]            oor_nxt;
    aidf_grp_cfg_t         cfg;

    assign hit     = sample.valid && !sample.cal && sample.chan == 3'(c);
    assign clip    = sample.code < 14'sh0000 || sample.code > `AIDF_RAW_MAX;
    assign x       = clamp_raw(sample.code); // [R13]
    assign acc_nxt = acc_r[c] + (14+AVG_SHIFT)'(x) - (14+AVG_SHIFT)'(acc_r[c] >> AVG_SHIFT);
    assign avg     = acc_nxt[AVG_SHIFT +: 13]; // [R07] never above 4200
    // Flag persists while a clipped sample is still inside the average
    assign oor_nxt = clip ? 8'((1 << AVG_SHIFT) * 4) : (oor_cnt_r[c] != 8'h00 ? oor_cnt_r[c] - 8'h01 : 8'h00);
    assign cfg     = in_grp_b(3'(c), eight_mode) ? grp_b : grp_a; // [R01]

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        acc_r[c]     <= '0;
        oor_cnt_r[c] <= 8'h00;
        word_r[c]    <= 16'h0000;
      end
      else if (hit)
      begin
        acc_r[c]     <= acc_nxt;
        oor_cnt_r[c] <= oor_nxt;
        word_r[c][`AIDF_DW_OOR] <= (oor_nxt != 8'h00); // [R11] [R12]
        word_r[c][`AIDF_DW_ERR] <= 1'b0; // [R11] [R12]
        // Bipolar spans fall back to raw counts; converted word has no sign
        if (cfg.scaled_decimal_format && cfg.full_scale_span inside {AIDF_RNG_0_5, AIDF_RNG_0_10, AIDF_RNG_1_5})
          word_r[c][13:0] <= to_decimal(avg, cfg.full_scale_span); // [R08] [R09] [R10] [R14]
        else
          word_r[c][13:0] <= {1'b0, avg}; // [R07] [R14]
      end
    end
  end

  // Indicator lit while any active channel holds a clipped sample
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      oor_led <= 1'b0;
    else
      oor_led <= (word_r[0][15] | word_r[1][15] | word_r[2][15] | word_r[3][15])
                 | (eight_mode & (word_r[4][15] | word_r[5][15] | word_r[6][15] | word_r[7][15])); // [R12]
  end

  // Write channel: address and data accepted in either order
  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h00000000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r     <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r     <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r[7:2] <= 6'h03) ? 2'b00 : 2'b10; // Data words are read only
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Control and mask registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= `AIDF_CTRL_RESET;
      mask_r <= 3'h0;
    end
    else if (wr_go)
    begin
      if (aw_addr_r[7:2] == 6'(`AIDF_OFS_CTRL >> 2))
      begin
        if (w_strb_r[0])
          ctrl_r[7:0] <= w_data_r[7:0];
        if (w_strb_r[1])
          ctrl_r[9:8] <= w_data_r[9:8];
      end
      if (aw_addr_r[7:2] == 6'(`AIDF_OFS_MASK >> 2) && w_strb_r[0])
        mask_r <= w_data_r[2:0];
    end
  end

  // Sticky status; a new event wins over a same-cycle clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_r <= 3'h0;
    else
    begin
      for (int b = 0; b < 3; b++)
      begin
        if (wr_go && aw_addr_r[7:2] == 6'(`AIDF_OFS_STATUS >> 2) && w_strb_r[0] && w_data_r[b])
          status_r[b] <= 1'b0;
      end
      if (ev_oor)
        status_r[`AIDF_ST_OOR] <= 1'b1;
      if (ev_cal)
        status_r[`AIDF_ST_CAL] <= 1'b1;
      if (ev_scan)
        status_r[`AIDF_ST_SCAN] <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(status_r & mask_r);
  end

  // Read channel: one cycle from address to data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h00000000;
      if (s_axi_araddr[7:2] == 6'(`AIDF_OFS_CTRL >> 2))
        s_axi_rdata <= {22'h000000, ctrl_r};
      else if (s_axi_araddr[7:2] == 6'(`AIDF_OFS_STATUS >> 2))
        s_axi_rdata <= {29'h00000000, status_r};
      else if (s_axi_araddr[7:2] == 6'(`AIDF_OFS_MASK >> 2))
        s_axi_rdata <= {29'h00000000, mask_r};
      else if (s_axi_araddr[7:2] == 6'(`AIDF_OFS_CALTRIM >> 2))
        s_axi_rdata <= {{24{trim_r[7]}}, trim_r};
      else if (s_axi_araddr >= `AIDF_OFS_DATA0 && s_axi_araddr <= `AIDF_OFS_DATA7)
        s_axi_rdata <= {16'h0000, word_r[3'(s_axi_araddr[7:2] - 6'h04)]}; // [R14]
      else
        s_axi_rresp <= 2'b10; // Unmapped
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  assign conv     = conv_r;
  assign cal_trim = trim_r;

endmodule : aidf_top

// *** verif/aidf_chk.sv ***
`timescale 1ns/1ps
module aidf_chk
  import aidf_pkg::*;
#(
  parameter int SLOT4_CYC = 20,
  parameter int SLOT8_CYC = 20
)(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire aidf_sample_t      sample,
  input wire aidf_conv_req_t    conv,
  input wire logic signed [7:0] cal_trim,
  input wire logic              oor_led
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [15:0] gap_r;
  logic        cal_s;
  logic        clip_s;

  // Sample kinds
  assign cal_s  = sample.valid && sample.cal;
  assign clip_s = sample.valid && !sample.cal && sample.chan < 3'h4
                  && (sample.code < 14'sh0000 || sample.code > 14'sh1068);

  // Cycles since last slot request; a stalled scheduler shows here
  always_ff @(posedge aclk)
  begin
    if (!aresetn || conv.req)
      gap_r <= 16'h0000;
    else
      gap_r <= gap_r + 16'h0001;
  end

  slot_gap_a: assert property (gap_r <= 16'(SLOT4_CYC > SLOT8_CYC ? SLOT4_CYC : SLOT8_CYC))
    else $error("slot request overdue");
  slot_space_a: assert property (conv.req |=> !conv.req [*8])
    else $error("slot requests too close");
  trim_down_a: assert property (cal_s && sample.code > 14'sh0802 && cal_trim != 8'sh80
    |=> cal_trim == $past(cal_trim) - 8'sh01) else $error("trim not lowered");
  trim_up_a: assert property (cal_s && sample.code < 14'sh07FE && cal_trim != 8'sh7F
    |=> cal_trim == $past(cal_trim) + 8'sh01) else $error("trim not raised");
  trim_hold_a: assert property (!cal_s |=> $stable(cal_trim))
    else $error("trim moved without cause");
  oor_led_a: assert property (clip_s |-> ##2 oor_led)
    else $error("indicator not lit on clip");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");

  clip_c: cover property (clip_s);
  cal_c: cover property (cal_s ##1 cal_trim != 8'sh00);
  rd_c: cover property (s_axi_arvalid && s_axi_arready);
endmodule : aidf_chk

bind aidf_top aidf_chk #(.SLOT4_CYC(SLOT4_CYC), .SLOT8_CYC(SLOT8_CYC)) aidf_chk_inst (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .sample, .conv, .cal_trim, .oor_led
);

// *** verif/aidf_conv_model.sv ***
`timescale 1ns/1ps
module aidf_conv_model
  import aidf_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire aidf_conv_req_t     conv,
  input  wire logic               slow,
  input  wire logic signed [13:0] level,
  input  wire logic signed [13:0] cal_level,
  output aidf_sample_t            sample
);
  aidf_conv_req_t pend_r;
  logic [2:0]     wait_r;

  // One result per request; slow mode stretches conversion time
  always_ff @(posedge aclk)
  begin
    sample.valid <= 1'b0;
    sample.code  <= ~sample.code; // Junk between results: the last code and its inverse alternate
    if (!aresetn)
    begin
      pend_r <= '0;
      wait_r <= 3'h0;
      sample <= '0;
    end
    else if (conv.req)
    begin
      pend_r <= conv;
      wait_r <= slow ? 3'h6 : 3'h0;
    end
    else if (pend_r.req && wait_r != 3'h0)
      wait_r <= wait_r - 3'h1;
    else if (pend_r.req)
    begin
      pend_r.req   <= 1'b0;
      sample.valid <= 1'b1;
      sample.cal   <= pend_r.cal;
      sample.chan  <= pend_r.chan;
      sample.code  <= pend_r.cal ? cal_level : level;
    end
  end
endmodule : aidf_conv_model

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    checks_done++; \
    if ((e) !== (g)) \
    begin \
      error_cnt++; \
      $display("Error %s expected %0h seen %0h", n, e, g); \
    end \
  end
module tb_top
  import aidf_pkg::*;
;
  logic aclk, aresetn, slow, oor_led, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic signed [7:0] cal_trim;
  logic signed [13:0] level, cal_level;
  aidf_sample_t sample;
  aidf_conv_req_t conv;
  int error_cnt, checks_done;

  aidf_top #(.SLOT4_CYC(20), .SLOT8_CYC(20)) aidf_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sample, .conv, .cal_trim, .oor_led, .irq
  );
  aidf_conv_model aidf_conv_model_inst (.aclk, .aresetn, .conv, .slow, .level, .cal_level, .sample);

  // 40 MHz
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Handshakes judged at the rising edge; registered outputs still show their pre-edge value here
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic tb;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      tb = 1'b0;
      while (!tb)
      begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready)
          s_axi_wvalid <= 1'b0;
        tb = s_axi_bvalid;
        r = s_axi_bresp;
      end
      `CHK("bresp", er, r)
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic tr;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      tr = 1'b0;
      while (!tr)
      begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready)
          s_axi_arvalid <= 1'b0;
        tr = s_axi_rvalid;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
    end
  endtask : rd

  function automatic logic [15:0] exp_word(logic [9:0] c, int ch, int lv);
    int raw;
    logic b;
    logic [2:0] sp;
    begin
      b = c[0] ? ch >= 4 : ch >= 2;
      sp = b ? c[7:5] : c[3:1];
      raw = lv < 0 ? 0 : lv > 4200 ? 4200 : lv;
      if ((b ? c[8] : c[4]) && sp < 3)
        raw = (raw * (sp == 1 ? 10000 : sp == 2 ? 4000 : 5000) + 2048) / 4096 + (sp == 2 ? 1000 : 0);
      raw = raw > 9999 ? 9999 : raw;
      return {lv < 0 || lv > 4200, 1'b0, 14'(raw)};
    end
  endfunction : exp_word

  // Settle 30 samples a channel in eight mode, 54 in four, so the average and clip hold have run out
  task automatic scan(input logic [9:0] c, input int lv);
    logic [15:0] e;
    int dv;
    begin
      wr(8'h00, {22'h000000, c}, 2'b00);
      level <= 14'(lv);
      repeat (5400) @(posedge aclk);
      for (int ch = 0; ch < (c[0] ? 8 : 4); ch++)
      begin
        rd(8'h10 + 8'(ch * 4));
        e = exp_word(c, ch, lv);
        dv = int'(d[13:0]) - int'(e[13:0]);
        `CHK("word_flags", e[15:14], d[15:14])
        `CHK("word_value", 1'b1, dv <= 10 && dv >= -10)
      end
    end
  endtask : scan

  task automatic results;
    begin
      $display("Checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask : results

  // Main sequence
  initial
  begin
    logic [2:0] sa, sb;
    void'($urandom(23302));
    {aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready} = '1;
    level = 14'sh0000;
    cal_level = 14'sh0800;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00);
    `CHK("ctrl", 32'h00000201, d)
    `CHK("rresp_ok", 2'b00, r)
    // Low byte only: upper control bits must keep their reset value
    s_axi_wstrb <= 4'h1;
    wr(8'h00, 32'h00000000, 2'b00);
    rd(8'h00);
    `CHK("ctrl_strb", 32'h00000200, d)
    s_axi_wstrb <= 4'hF;
    rd(8'h40);
    `CHK("rresp", 2'b10, r)
    wr(8'h10, 32'h00001234, 2'b10);
    scan(10'h211, 2048);
    scan(10'h352, 2048);
    scan(10'h287, 4500);
    rd(8'h04);
    `CHK("clip_status", 1'b1, d[0])
    wr(8'h08, 32'h00000001, 2'b00);
    repeat (2) @(negedge aclk);
    `CHK("irq_on", 1'b1, irq)
    `CHK("led_on", 1'b1, oor_led)
    @(posedge aclk);
    scan(10'h201, -300);
    scan(10'h201, 4200);
    wr(8'h04, 32'h00000007, 2'b00);
    @(negedge aclk);
    `CHK("irq_off", 1'b0, irq)
    `CHK("led_off", 1'b0, oor_led)
    @(posedge aclk);
    cal_level <= 14'sh0900;
    repeat (900) @(posedge aclk);
    rd(8'h0C);
    `CHK("trim_neg", 1'b1, d[7])
    `CHK("trim_ext", d[7], d[31])
    rd(8'h04);
    `CHK("cal_status", 1'b1, d[1])
    cal_level <= 14'sh0700;
    repeat (900) @(posedge aclk);
    cal_level <= 14'sh0800;
    for (int i = 0; i < 5; i++)
    begin
      sa = 3'($urandom_range(0, 4));
      sb = 3'($urandom_range(0, 4));
      slow <= 1'($urandom);
      scan({1'b1, (sb < 3) & 1'($urandom), sb, (sa < 3) & 1'($urandom), sa, 1'($urandom)},
           int'($urandom_range(0, 4400)) - 100);
    end
    results();
  end

  // Watchdog
  initial
  begin
    repeat (75000) @(posedge aclk);
    error_cnt++;
    results();
  end
endmodule : tb_top
